/* File: logic/udb_fifo.sv */
`timescale 1ns/1ps
module udb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RESET,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge SYS_CLK) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_bound_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        count <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
    fifo_full_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        (!in_ready && !pop) |=> !in_ready) else $error("fifo full dropped");
endmodule

/* File: logic/udb_pkg.sv */
package udb_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] UDB_ADDR_DATA     = 8'h99;
    localparam logic [7:0] UDB_DATA_RESET    = 8'h00;
    // ==========================================================
    // Bit-rate timer
    localparam logic [1:0] UDB_PRE_DIV12     = 2'h0;
    localparam logic [1:0] UDB_PRE_DIV4      = 2'h1;
    localparam logic [1:0] UDB_PRE_DIV48     = 2'h2;
    localparam logic [5:0] UDB_DIV12         = 6'h0c;
    localparam logic [5:0] UDB_DIV4          = 6'h04;
    localparam logic [5:0] UDB_DIV48         = 6'h30;
    localparam logic [1:0] UDB_OVF_PER_BIT   = 2'h2;
    // ==========================================================
    // Frame
    localparam logic [3:0] UDB_DATA_BITS     = 4'h8;
    localparam logic [3:0] UDB_FRAME_BITS    = 4'hb;
    localparam int         UDB_FIFO_DEPTH    = 16;
    localparam int         UDB_FIFO_WIDTH    = 8;
    typedef enum logic [1:0] {UDB_TX_IDLE, UDB_TX_SHIFT} udb_tx_e;
endpackage

/* File: logic/udb_top.sv */
`timescale 1ns/1ps
module udb_top (
    input  wire logic       SYS_CLK,
    input  wire logic       RESET,
    input  wire logic [7:0] ADDR,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    input  wire logic [7:0] WDATA,
    output logic      [7:0] RDATA,
    output logic            WR_READY,
    input  wire logic       TIMER_CLOCK_SELECT,
    input  wire logic [1:0] TIMER_PRESCALE_SELECT,
    input  wire logic [7:0] RELOAD,
    input  wire logic       NINE_BIT_MODE,
    input  wire logic       TX_NINTH_BIT,
    input  wire logic       RECEIVE_ENABLE,
    input  wire logic       MULTIPROC_CHECK_ENABLE,
    input  wire logic       TRANSMIT_DONE_CLEAR,
    input  wire logic       RECEIVE_DONE_CLEAR,
    output logic            TRANSMIT_DONE_FLAG,
    output logic            RECEIVE_DONE_FLAG,
    output logic            RX_NINTH_BIT,
    input  wire logic       RXD,
    output logic            TXD
);
    // ==========================================================
    // Bit-rate timer
    logic [5:0] pre_cnt;
    logic [5:0] pre_div;
    logic       tick;
    logic [7:0] timer;
    logic       ovf;
    logic       bit_tick;
    logic       half;

    function automatic logic [5:0] div_of(input logic [1:0] sel);
        if (sel == udb_pkg::UDB_PRE_DIV4) begin
            return udb_pkg::UDB_DIV4;
        end else if (sel == udb_pkg::UDB_PRE_DIV48) begin
            return udb_pkg::UDB_DIV48;
        end else begin
            return udb_pkg::UDB_DIV12;
        end
    endfunction

    function automatic logic data_addr(input logic [7:0] addr);
        return addr == udb_pkg::UDB_ADDR_DATA;
    endfunction

    function automatic logic last_slot(input logic [3:0] cnt, input logic [3:0] total);
        return cnt == total - 4'h1;
    endfunction

    assign pre_div  = div_of(TIMER_PRESCALE_SELECT);
    // At or above, so a smaller divisor picked mid-count cannot wrap the counter
    assign tick     = TIMER_CLOCK_SELECT || (pre_cnt >= pre_div - 6'h01);
    assign ovf      = tick && (timer == 8'hff);
    assign bit_tick = ovf && half;

    always_ff @(posedge SYS_CLK) begin
        if (RESET || tick || TIMER_CLOCK_SELECT) begin
            pre_cnt <= 6'h00;
        end else begin
            pre_cnt <= pre_cnt + 6'h01;
        end
    end

    // Auto-reload; two overflows make one bit time
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            timer <= 8'h00;
            half  <= 1'b0;
        end else if (tick) begin
            timer <= ovf ? RELOAD : timer + 8'h01;
            if (ovf) begin
                half <= !half;
            end
        end
    end

    // ==========================================================
    // Transmit path, with a FIFO ahead of the shifter
    logic       fifo_valid;
    logic       fifo_ready;
    logic [7:0] fifo_data;
    logic       wr_hit;
    udb_pkg::udb_tx_e tx_state;
    logic [9:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] tx_total;

    assign wr_hit     = WR_EN && data_addr(ADDR);
    assign tx_total   = NINE_BIT_MODE ? udb_pkg::UDB_FRAME_BITS : udb_pkg::UDB_FRAME_BITS - 4'h1;
    assign fifo_ready = (tx_state == udb_pkg::UDB_TX_IDLE) && bit_tick;

    udb_fifo #(.WIDTH(udb_pkg::UDB_FIFO_WIDTH), .DEPTH(udb_pkg::UDB_FIFO_DEPTH)) u_fifo (
        .SYS_CLK   (SYS_CLK),
        .RESET     (RESET),
        .in_valid  (wr_hit),
        .in_ready  (WR_READY),
        .in_data   (WDATA),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            tx_state <= udb_pkg::UDB_TX_IDLE;
            tx_shift <= '1;
            tx_cnt   <= 4'h0;
            TXD      <= 1'b1;
        end else if (bit_tick) begin
            case (tx_state)
                udb_pkg::UDB_TX_IDLE: begin
                    TXD <= 1'b1;
                    if (fifo_valid) begin
                        // Start bit now; data LSB first, then ninth bit in nine-bit mode, then stop
                        TXD      <= 1'b0;
                        tx_shift <= {1'b1, NINE_BIT_MODE ? TX_NINTH_BIT : 1'b1, fifo_data};
                        tx_cnt   <= 4'h1;
                        tx_state <= udb_pkg::UDB_TX_SHIFT;
                    end
                end
                udb_pkg::UDB_TX_SHIFT: begin
                    TXD      <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_cnt   <= tx_cnt + 4'h1;
                    if (last_slot(tx_cnt, tx_total)) begin
                        tx_state <= udb_pkg::UDB_TX_IDLE;
                    end
                end
                default: tx_state <= udb_pkg::UDB_TX_IDLE;
            endcase
        end
    end

    logic tx_stop_start;
    assign tx_stop_start = bit_tick && (tx_state == udb_pkg::UDB_TX_SHIFT) && last_slot(tx_cnt, tx_total);

    // Set wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            TRANSMIT_DONE_FLAG <= 1'b0;
        end else if (tx_stop_start) begin
            TRANSMIT_DONE_FLAG <= 1'b1;
        end else if (TRANSMIT_DONE_CLEAR) begin
            TRANSMIT_DONE_FLAG <= 1'b0;
        end
    end

    // ==========================================================
    // Receive path, sampled at one point per bit (mid-bit half-overflow)
    logic       rx_s1;
    logic       rx_s2;
    logic       rx_busy;
    logic [3:0] rx_cnt;
    logic [9:0] rx_shift;
    logic [7:0] rx_latch;
    logic       rx_mid;
    logic       rx_done;
    logic       rx_accept;

    assign rx_mid    = ovf && !half;
    assign rx_done   = rx_busy && rx_mid && last_slot(rx_cnt, tx_total);
    assign rx_accept = rx_done && !RECEIVE_DONE_FLAG &&
                       (!MULTIPROC_CHECK_ENABLE || (NINE_BIT_MODE ? rx_shift[9] : rx_s2));

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= RXD;
            rx_s2 <= rx_s1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rx_busy  <= 1'b0;
            rx_cnt   <= 4'h0;
            rx_shift <= '0;
        end else if (!rx_busy) begin
            if (RECEIVE_ENABLE && rx_mid && !rx_s2) begin
                rx_busy <= 1'b1;
                rx_cnt  <= 4'h1;
            end
        end else if (rx_mid) begin
            rx_cnt   <= rx_cnt + 4'h1;
            rx_shift <= {rx_s2, rx_shift[9:1]};
            if (rx_done) begin
                rx_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rx_latch     <= udb_pkg::UDB_DATA_RESET;
            RX_NINTH_BIT <= 1'b0;
        end else if (rx_accept) begin
            rx_latch     <= NINE_BIT_MODE ? rx_shift[8:1] : rx_shift[9:2];
            RX_NINTH_BIT <= NINE_BIT_MODE ? rx_shift[9] : rx_s2;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            RECEIVE_DONE_FLAG <= 1'b0;
        end else if (rx_accept) begin
            RECEIVE_DONE_FLAG <= 1'b1;
        end else if (RECEIVE_DONE_CLEAR) begin
            RECEIVE_DONE_FLAG <= 1'b0;
        end
    end

    // Read data registered, one cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            RDATA <= udb_pkg::UDB_DATA_RESET;
        end else if (RD_EN && data_addr(ADDR)) begin
            RDATA <= rx_latch;
        end
    end

    // ==========================================================
    // Checks
    // Pacing helpers; a prescale select change leaves the divider running, so one gap is skipped
    logic [1:0] ovf_seen;
    logic [5:0] tick_gap;
    logic [2:0] cfg_prev;
    logic       cfg_moved;
    logic       tick_steady;

    assign cfg_moved = {TIMER_CLOCK_SELECT, TIMER_PRESCALE_SELECT} != cfg_prev;

    always_ff @(posedge SYS_CLK) begin
        if (RESET || bit_tick) begin
            ovf_seen <= 2'h0;
        end else if (ovf) begin
            ovf_seen <= ovf_seen + 2'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET || tick) begin
            tick_gap <= 6'h00;
        end else begin
            tick_gap <= tick_gap + 6'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cfg_prev    <= 3'h0;
            tick_steady <= 1'b0;
        end else begin
            cfg_prev <= {TIMER_CLOCK_SELECT, TIMER_PRESCALE_SELECT};
            if (cfg_moved) begin
                tick_steady <= 1'b0;
            end else if (tick) begin
                tick_steady <= 1'b1;
            end
        end
    end

    sequence tx_start_s;
        bit_tick && tx_state == udb_pkg::UDB_TX_IDLE && fifo_valid;
    endsequence

    tx_start_low_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        tx_start_s |=> !TXD) else $error("start bit not driven");
    tx_done_set_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        tx_stop_start |=> TRANSMIT_DONE_FLAG) else $error("transmit done not set");
    rx_flag_hold_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        (RECEIVE_DONE_FLAG && !RECEIVE_DONE_CLEAR) |=> $stable(rx_latch)) else $error("latch overwritten");
    rd_latch_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        (RD_EN && data_addr(ADDR)) |=> RDATA == $past(rx_latch)) else $error("read not latch");
    bit_two_ovf_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        bit_tick |-> ovf_seen == udb_pkg::UDB_OVF_PER_BIT - 2'h1) else $error("bit tick pacing");
    pre_sys_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        (tick && tick_steady && !cfg_moved) |->
        tick_gap == (TIMER_CLOCK_SELECT ? 6'h00 : div_of(TIMER_PRESCALE_SELECT) - 6'h01))
        else $error("timer clock pacing");
    tx_idle_high_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        (bit_tick && tx_state == udb_pkg::UDB_TX_IDLE && !fifo_valid) |=> TXD) else $error("idle line low");
    wr_queue_a : assert property (@(posedge SYS_CLK) disable iff (RESET)
        (wr_hit && WR_READY && tx_state == udb_pkg::UDB_TX_IDLE) |=> fifo_valid) else $error("write lost");
endmodule

/* File: testbench/uart_data_buffer_and_baud_setup_bench.sv */
`timescale 1ns/1ps
module uart_data_buffer_and_baud_setup_bench;
    logic       SYS_CLK = 1'b0, RESET = 1'b1, WR_EN = 1'b0, RD_EN = 1'b0, NINE_BIT_MODE = 1'b1;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RELOAD = 8'hfc, RDATA, rd;
    logic [1:0] TIMER_PRESCALE_SELECT = 2'h0;
    logic       TIMER_CLOCK_SELECT = 1'b1, TX_NINTH_BIT = 1'b0, RECEIVE_ENABLE = 1'b1;
    logic       MULTIPROC_CHECK_ENABLE = 1'b0, TRANSMIT_DONE_CLEAR = 1'b0, RECEIVE_DONE_CLEAR = 1'b0;
    logic       WR_READY, TRANSMIT_DONE_FLAG, RECEIVE_DONE_FLAG, RX_NINTH_BIT, RXD, TXD;
    logic [9:0] got;
    int         bit_cycles = 8, failures = 0, checks = 0;

    udb_top dut_u (.SYS_CLK, .RESET, .ADDR, .WR_EN, .RD_EN, .WDATA, .RDATA, .WR_READY, .TIMER_CLOCK_SELECT,
        .TIMER_PRESCALE_SELECT, .RELOAD, .NINE_BIT_MODE, .TX_NINTH_BIT, .RECEIVE_ENABLE, .MULTIPROC_CHECK_ENABLE,
        .TRANSMIT_DONE_CLEAR, .RECEIVE_DONE_CLEAR, .TRANSMIT_DONE_FLAG, .RECEIVE_DONE_FLAG, .RX_NINTH_BIT,
        .RXD, .TXD);
    udb_partner far_u (.clk(SYS_CLK), .bit_cycles(bit_cycles), .txd(TXD), .rxd(RXD));

    always #20 SYS_CLK = ~SYS_CLK;

    // ==========================================================
    // Shared helpers
    task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task write_byte(input logic [7:0] d);
        for (int n = 0; n < 30000 && WR_READY !== 1'b1; n++) @(negedge SYS_CLK);
        check("write ready", WR_READY, 1'b1);
        ADDR = udb_pkg::UDB_ADDR_DATA;
        WDATA = d;
        WR_EN = 1'b1;
        @(negedge SYS_CLK);
        WR_EN = 1'b0;
    endtask

    task read_byte(output logic [7:0] d);
        @(negedge SYS_CLK);
        ADDR = udb_pkg::UDB_ADDR_DATA;
        RD_EN = 1'b1;
        @(negedge SYS_CLK);
        RD_EN = 1'b0;
        @(negedge SYS_CLK);
        d = RDATA;
    endtask

    task take_frame(output logic [9:0] v);
        v = 'x;
        for (int n = 0; n < 30000 && far_u.got_q.size() == 0; n++) @(negedge SYS_CLK);
        if (far_u.got_q.size() > 0) v = far_u.got_q.pop_front();
    endtask

    task clear_flags;
        @(negedge SYS_CLK);
        TRANSMIT_DONE_CLEAR = 1'b1;
        RECEIVE_DONE_CLEAR = 1'b1;
        @(negedge SYS_CLK);
        TRANSMIT_DONE_CLEAR = 1'b0;
        RECEIVE_DONE_CLEAR = 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task test_reset;
        check("rdata", {2'h0, RDATA}, {2'h0, udb_pkg::UDB_DATA_RESET});
        check("txd idle", TXD, 1'b1);
        check("flags", {TRANSMIT_DONE_FLAG, RECEIVE_DONE_FLAG}, 2'h0);
        $display("test reset done");
    endtask

    task test_tx;
        TX_NINTH_BIT = 1'b1;
        write_byte(8'ha5);
        take_frame(got);
        check("tx frame", got, 10'h3a5);
        check("tx done", TRANSMIT_DONE_FLAG, 1'b1);
        read_byte(rd);
        check("read after write", {2'h0, rd}, 10'h000);
        clear_flags();
        check("tx done cleared", TRANSMIT_DONE_FLAG, 1'b0);
        $display("test tx done");
    endtask

    task test_rx;
        far_u.send(8'h3c, 1'b0);
        repeat (4) @(negedge SYS_CLK);
        check("rx flag", RECEIVE_DONE_FLAG, 1'b1);
        check("rx ninth", RX_NINTH_BIT, 1'b0);
        // Second byte must be dropped while the flag is still up
        far_u.send(8'hc3, 1'b1);
        repeat (4) @(negedge SYS_CLK);
        read_byte(rd);
        check("rx latch kept", {2'h0, rd}, 10'h03c);
        clear_flags();
        MULTIPROC_CHECK_ENABLE = 1'b1;
        far_u.send(8'h55, 1'b0);
        repeat (4) @(negedge SYS_CLK);
        check("mp data dropped", RECEIVE_DONE_FLAG, 1'b0);
        far_u.send(8'haa, 1'b1);
        repeat (4) @(negedge SYS_CLK);
        read_byte(rd);
        check("mp address", {RECEIVE_DONE_FLAG, RX_NINTH_BIT, rd}, 10'h3aa);
        MULTIPROC_CHECK_ENABLE = 1'b0;
        clear_flags();
        $display("test rx done");
    endtask

    task test_fill;
        int n;
        n = 0;
        @(negedge SYS_CLK);
        ADDR = udb_pkg::UDB_ADDR_DATA;
        WR_EN = 1'b1;
        while (WR_READY === 1'b1 && n < 20) begin
            WDATA = n[7:0];
            n++;
            @(negedge SYS_CLK);
        end
        WDATA = 8'hee;
        @(negedge SYS_CLK);
        WR_EN = 1'b0;
        check("full refuses", {WR_READY, 1'b0}, 2'h0);
        check("queued count", (n >= udb_pkg::UDB_FIFO_DEPTH && n <= 18), 1'b1);
        for (int i = 0; i < n; i++) begin
            take_frame(got);
            check("queued frame", got, {2'h3, i[7:0]});
        end
        repeat (bit_cycles * 14) @(negedge SYS_CLK);
        check("no extra frame", far_u.got_q.size(), 10'h000);
        $display("test fill done");
    endtask

    task test_rates;
        logic [18:0] tab[7];
        int          w;
        // Select 11 has no listed divisor; it is held to behave as divide by 12
        tab = '{{1'b1, 2'h0, 8'hfc, 8'h08}, {1'b0, 2'h0, 8'hff, 8'h18}, {1'b0, 2'h1, 8'hff, 8'h08},
                {1'b0, 2'h2, 8'hff, 8'h60}, {1'b1, 2'h0, 8'h96, 8'hd4}, {1'b1, 2'h0, 8'ha0, 8'hc0},
                {1'b0, 2'h3, 8'hff, 8'h18}};
        NINE_BIT_MODE = 1'b0;
        foreach (tab[k]) begin
            {TIMER_CLOCK_SELECT, TIMER_PRESCALE_SELECT, RELOAD, rd} = tab[k];
            bit_cycles = rd;
            repeat (300) @(negedge SYS_CLK);
            write_byte(8'h01);
            for (int n = 0; n < 3000 && TXD !== 1'b0; n++) @(negedge SYS_CLK);
            for (w = 0; w < 3000 && TXD === 1'b0; w++) @(negedge SYS_CLK);
            check("bit time", w, {2'h0, rd});
            take_frame(got);
            check("rate frame", got, 10'h301);
        end
        $display("test rates done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge SYS_CLK);
        RESET = 1'b0;
        @(negedge SYS_CLK);
        test_reset();
        test_tx();
        test_rx();
        test_fill();
        test_rates();
        complete_run();
    end

    // Longest path is the rate table, about 8000 cycles
    initial begin
        #(40 * 60000);
        failures++;
        complete_run();
    end
endmodule

/* File: testbench/udb_partner.sv */
`timescale 1ns/1ps
// ==========================================================
// Remote serial transceiver on the line
module udb_partner (
    input  wire logic        clk,
    input  wire logic [31:0] bit_cycles,
    input  wire logic        txd,
    output logic             rxd
);
    logic [9:0] got_q[$];

    initial rxd = 1'b1; // Line idles high between frames

    // Eight-bit mode reads the ninth slot as the stop bit, so callers pass 1 there
    task automatic send(input logic [7:0] d, input logic ninth);
        logic [10:0] f;
        f = {1'b1, ninth, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge clk);
            rxd = f[i];
            repeat (bit_cycles - 1) @(negedge clk);
        end
    endtask

    // Mid-bit sampling of data, ninth and stop; bit 9 is idle in eight-bit mode
    always begin : rx_sample
        logic [9:0] v;
        @(negedge txd);
        repeat (bit_cycles / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (bit_cycles) @(posedge clk);
            v[i] = txd;
        end
        got_q.push_back(v);
    end
endmodule
